/* File: psr_regs.vh */
// Summary of operation
// - sensor-id register holds slot 6, 5, 4 ids at 14:10, 9:5, 4:0; bit 15 reserved.
// - six channel-1 earliest-start registers each hold a 12-bit start time in us.
// - channel-1 window end register holds a 12-bit end time in us.
// - monitoring and channel-2 config writes need odd parity over all 16 bits.
// - soft reset only on 0x5555 followed by 0xA5A5 in the very next transfer.
// - command 0x00FF clears channel-1 upstream buffer and its ready flag.
// - command 0xFF00 clears channel-2 upstream buffer and its ready flag.
// - command 0x1111 ends programming; configuration registers then refuse writes.
// - programming status reads 0 after lock, 1 after any reset or clock error.
// - 0x9999 enables self-test writes; setup register only during programming.
// - 0x9090 disables self-test writes; a status bit shows writability.
// - slot-1 format applies to all slots on init-data, simple monitoring or async.
// - channel-2 bit 13 selects sync step height, 0 low, 1 high.
// - channel-2 bit 12 makes the digital output an interrupt output.
// - channel-2 bits 11:10 pick off, standard (01) or simple (10) monitoring.
// - channel-2 bits 9:8 pick current limit: 00 19mA, 10 45mA, else 35mA.
// - channel-2 bit 7 stores sensor init data in a dedicated buffer.
// - channel-2 bits 6:4 give 1 to 6 slots, other codes give 3.
// - channel-2 bits 2:1 give bit rate: 01 189k, 10 83.3k, else 125k.
// - channel-2 bit 0 low is asynchronous, high is synchronous.
// - slots 1 to 4 each have check-type bit and length code 8..28, else 20 bits.
// - channel-2 register 2 bit 12 set disables the bootstrap circuit.
`ifndef PSR_REGS_VH
`define PSR_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define PSR_OFS_SENSOR_ID 6'h16
`define PSR_OFS_ES_FIRST 6'h17
`define PSR_OFS_ES_LAST 6'h1C
`define PSR_OFS_WIN_END 6'h1D
`define PSR_OFS_DIRECT_CMD 6'h1E
`define PSR_OFS_CH2_MAIN 6'h1F
`define PSR_OFS_CH2_S12 6'h20
`define PSR_OFS_CH2_S34 6'h21
// ****************************************
// reset values
// ****************************************
`define PSR_RST_SENSOR_ID 16'h39AC
`define PSR_RST_ES1 16'h002C
`define PSR_RST_ES2 16'h00B5
`define PSR_RST_ES3 16'h8149
`define PSR_RST_ES456 16'h8000
`define PSR_RST_WIN_END 16'h81EC
`define PSR_RST_CH2_MAIN 16'h0181
`define PSR_RST_CH2_FMT 16'h0514
// ****************************************
// command codes
// ****************************************
`define PSR_CMD_UNLOCK 16'h5555
`define PSR_CMD_RESET 16'hA5A5
`define PSR_CMD_CLR_UP1 16'h00FF
`define PSR_CMD_CLR_UP2 16'hFF00
`define PSR_CMD_LOCK 16'h1111
`define PSR_CMD_ST_ON 16'h9999
`define PSR_CMD_ST_OFF 16'h9090
// ****************************************
// field positions
// ****************************************
`define PSR_F_CHECK_BIT 15
`define PSR_F_PULSE_HEIGHT 13
`define PSR_F_PIN_ROLE 12
`define PSR_F_MON_HI 11
`define PSR_F_MON_LO 10
`define PSR_F_ILIM_HI 9
`define PSR_F_ILIM_LO 8
`define PSR_F_INIT_DATA 7
`define PSR_F_SLOTS_HI 6
`define PSR_F_SLOTS_LO 4
`define PSR_F_RATE_HI 2
`define PSR_F_RATE_LO 1
`define PSR_F_SYNC 0
`define PSR_F_BOOT_OFF 12
`define PSR_TIME_HI 11
`define PSR_MON_STD 2'h1
`define PSR_MON_SIMPLE 2'h2
`define PSR_LEN_MIN 5'h08
`define PSR_LEN_MAX 5'h1C
`define PSR_LEN_DEF 5'h14
`define PSR_SLOTS_DEF 3'h3
`endif

/* File: psr_config_regs.v */
`timescale 1ns/1ps
`include "psr_regs.vh"
module psr_config_regs (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire clk_err_i,
  // register access, one strobe per transfer
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [5:0] addr_i,
  input wire [15:0] wdata_i,
  output reg [15:0] rdata_o,
  output reg parity_err_o,
  output reg lock_refused_o,
  // commands and status
  output reg soft_reset_o,
  output reg ch1_upstream_clear_o,
  output reg ch2_upstream_clear_o,
  output wire prog_phase_o,
  output wire self_test_write_allowed_o,
  output wire self_test_setup_wr_en_o,
  output wire self_test_runtime_wr_en_o,
  // channel 1 slot ids and monitoring windows
  output wire [4:0] ch1_slot6_sensor_id_o,
  output wire [4:0] ch1_slot5_sensor_id_o,
  output wire [4:0] ch1_slot4_sensor_id_o,
  output wire [71:0] ch1_slot_start_time_o,
  output wire [11:0] ch1_window_end_time_o,
  // channel 2 configuration
  output wire ch2_pulse_height_select_o,
  output wire ch2_output_pin_role_o,
  output wire ch2_monitor_standard_o,
  output wire ch2_monitor_simple_o,
  output wire [1:0] ch2_current_limit_select_o,
  output wire ch2_store_init_data_o,
  output wire [2:0] ch2_slot_count_o,
  output wire [1:0] ch2_bit_rate_o,
  output wire ch2_synchronous_mode_o,
  output wire ch2_bootstrap_off_o,
  output wire [3:0] ch2_check_type_o,
  output wire [19:0] ch2_data_length_o
);

  // ****************************************
  // length decode
  // ****************************************
  function [4:0] psr_len;
    input [4:0] code;
    begin
      if (code >= `PSR_LEN_MIN && code <= `PSR_LEN_MAX)
        psr_len = code;
      else
        psr_len = `PSR_LEN_DEF;
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg clk_err_meta_r;
  reg clk_err_r;
  reg [15:0] sensor_id_r;
  reg [15:0] es_r [0:5];
  reg [15:0] win_end_r;
  reg [15:0] ch2_main_r;
  reg [15:0] ch2_s12_r;
  reg [15:0] ch2_s34_r;
  reg prog_r;
  reg st_en_r;
  reg st_setup_r;
  reg unlock_r;
  reg [15:0] rdata_nxt;
  integer i;

  wire access = wr_en_i | rd_en_i;
  wire cmd_wr = wr_en_i && addr_i == `PSR_OFS_DIRECT_CMD;
  wire odd_ok = ^wdata_i;
  wire in_es = addr_i >= `PSR_OFS_ES_FIRST && addr_i <= `PSR_OFS_ES_LAST;
  wire [5:0] es_idx = addr_i - `PSR_OFS_ES_FIRST;
  wire needs_par = in_es || addr_i == `PSR_OFS_WIN_END ||
    addr_i == `PSR_OFS_CH2_MAIN || addr_i == `PSR_OFS_CH2_S12 ||
    addr_i == `PSR_OFS_CH2_S34;
  wire cfg_addr = needs_par || addr_i == `PSR_OFS_SENSOR_ID;
  wire cfg_wr = wr_en_i && cfg_addr && prog_r && (odd_ok || !needs_par);
  wire do_soft_rst = cmd_wr && unlock_r && wdata_i == `PSR_CMD_RESET;
  // clock error behaves as a device reset for the programming state
  wire full_rst = rst_i || do_soft_rst || clk_err_r;

  // ****************************************
  // pin synchroniser
  // ****************************************
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      clk_err_meta_r <= 1'b0;
      clk_err_r <= 1'b0;
    end
    else if (ce_i)
    begin
      clk_err_meta_r <= clk_err_i;
      clk_err_r <= clk_err_meta_r;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge ref_clk_i)
  begin
    if (rst_i || (ce_i && do_soft_rst))
    begin
      sensor_id_r <= `PSR_RST_SENSOR_ID;
      es_r[0] <= `PSR_RST_ES1;
      es_r[1] <= `PSR_RST_ES2;
      es_r[2] <= `PSR_RST_ES3;
      for (i = 3; i < 6; i = i + 1)
        es_r[i] <= `PSR_RST_ES456;
      win_end_r <= `PSR_RST_WIN_END;
      ch2_main_r <= `PSR_RST_CH2_MAIN;
      ch2_s12_r <= `PSR_RST_CH2_FMT;
      ch2_s34_r <= `PSR_RST_CH2_FMT;
    end
    else if (ce_i && cfg_wr)
    begin
      if (addr_i == `PSR_OFS_SENSOR_ID)
        sensor_id_r <= {1'b0, wdata_i[14:0]};
      if (in_es)
        es_r[es_idx[2:0]] <= {wdata_i[15], 3'h0, wdata_i[11:0]};
      if (addr_i == `PSR_OFS_WIN_END)
        win_end_r <= {wdata_i[15], 3'h0, wdata_i[11:0]};
      if (addr_i == `PSR_OFS_CH2_MAIN)
        ch2_main_r <= {wdata_i[15], 1'b0, wdata_i[13:4], 1'b0, wdata_i[2:0]};
      if (addr_i == `PSR_OFS_CH2_S12)
        ch2_s12_r <= {3'h0, wdata_i[12:0]};
      if (addr_i == `PSR_OFS_CH2_S34)
        ch2_s34_r <= {4'h0, wdata_i[11:0]};
    end
  end

  // ****************************************
  // direct commands
  // ****************************************
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      prog_r <= 1'b1;
      st_en_r <= 1'b0;
      st_setup_r <= 1'b0;
      unlock_r <= 1'b0;
      soft_reset_o <= 1'b0;
      ch1_upstream_clear_o <= 1'b0;
      ch2_upstream_clear_o <= 1'b0;
    end
    else if (ce_i)
    begin
      soft_reset_o <= do_soft_rst;
      ch1_upstream_clear_o <= cmd_wr && wdata_i == `PSR_CMD_CLR_UP1;
      ch2_upstream_clear_o <= cmd_wr && wdata_i == `PSR_CMD_CLR_UP2;
      // any transfer other than the unlock drops the pending unlock
      if (access)
        unlock_r <= cmd_wr && wdata_i == `PSR_CMD_UNLOCK;
      if (full_rst)
      begin
        prog_r <= 1'b1;
        st_en_r <= 1'b0;
        st_setup_r <= 1'b0;
      end
      else if (cmd_wr)
      begin
        case (wdata_i)
          `PSR_CMD_LOCK:
          begin
            prog_r <= 1'b0;
            st_setup_r <= 1'b0;
          end
          `PSR_CMD_ST_ON:
          begin
            st_en_r <= 1'b1;
            st_setup_r <= prog_r;
          end
          `PSR_CMD_ST_OFF:
          begin
            st_en_r <= 1'b0;
            st_setup_r <= 1'b0;
          end
          default:
            st_en_r <= st_en_r;
        endcase
      end
    end
  end

  // ****************************************
  // read-back and error flags
  // ****************************************
  always @*
  begin
    rdata_nxt = 16'h0000;
    if (in_es)
      rdata_nxt = es_r[es_idx[2:0]];
    else
    begin
      case (addr_i)
        `PSR_OFS_SENSOR_ID: rdata_nxt = sensor_id_r;
        `PSR_OFS_WIN_END: rdata_nxt = win_end_r;
        `PSR_OFS_CH2_MAIN: rdata_nxt = ch2_main_r;
        `PSR_OFS_CH2_S12: rdata_nxt = ch2_s12_r;
        `PSR_OFS_CH2_S34: rdata_nxt = ch2_s34_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 16'h0000;
      parity_err_o <= 1'b0;
      lock_refused_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rd_en_i)
        rdata_o <= rdata_nxt;
      parity_err_o <= wr_en_i && needs_par && !odd_ok;
      lock_refused_o <= wr_en_i && cfg_addr && !prog_r;
    end
  end

  // ****************************************
  // decoded outputs
  // ****************************************
  assign prog_phase_o = prog_r;
  assign self_test_write_allowed_o = st_en_r;
  assign self_test_runtime_wr_en_o = st_en_r;
  assign self_test_setup_wr_en_o = st_en_r && st_setup_r && prog_r;

  assign ch1_slot6_sensor_id_o = sensor_id_r[14:10];
  assign ch1_slot5_sensor_id_o = sensor_id_r[9:5];
  assign ch1_slot4_sensor_id_o = sensor_id_r[4:0];
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_es
      assign ch1_slot_start_time_o[g*12 +: 12] =
        es_r[g][`PSR_TIME_HI:0];
    end
  endgenerate
  assign ch1_window_end_time_o = win_end_r[`PSR_TIME_HI:0];

  wire [1:0] mon = ch2_main_r[`PSR_F_MON_HI:`PSR_F_MON_LO];
  wire [1:0] ilim = ch2_main_r[`PSR_F_ILIM_HI:`PSR_F_ILIM_LO];
  wire [1:0] rate = ch2_main_r[`PSR_F_RATE_HI:`PSR_F_RATE_LO];
  wire [2:0] slots = ch2_main_r[`PSR_F_SLOTS_HI:`PSR_F_SLOTS_LO];

  assign ch2_pulse_height_select_o = ch2_main_r[`PSR_F_PULSE_HEIGHT];
  assign ch2_output_pin_role_o = ch2_main_r[`PSR_F_PIN_ROLE];
  assign ch2_monitor_standard_o = mon == `PSR_MON_STD;
  assign ch2_monitor_simple_o = mon == `PSR_MON_SIMPLE;
  // 0: 19 mA, 1: 35 mA, 2: 45 mA
  assign ch2_current_limit_select_o = (ilim == 2'h3) ? 2'h1 : ilim;
  assign ch2_store_init_data_o = ch2_main_r[`PSR_F_INIT_DATA];
  assign ch2_slot_count_o = (slots == 3'h0 || slots == 3'h7) ?
    `PSR_SLOTS_DEF : slots;
  // 0: 125 kb/s, 1: 189 kb/s, 2: 83.3 kb/s
  assign ch2_bit_rate_o = (rate == 2'h3) ? 2'h0 : rate;
  assign ch2_synchronous_mode_o = ch2_main_r[`PSR_F_SYNC];
  assign ch2_bootstrap_off_o = ch2_s12_r[`PSR_F_BOOT_OFF];

  // slot 1 overrides the others without touching the stored registers
  wire use_slot1 = ch2_store_init_data_o || ch2_monitor_simple_o ||
    !ch2_synchronous_mode_o;
  wire [23:0] fmt_raw = {ch2_s34_r[11:0], ch2_s12_r[11:0]};
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_fmt
      wire [5:0] f = use_slot1 ? fmt_raw[5:0] : fmt_raw[g*6 +: 6];
      assign ch2_check_type_o[g] = f[5];
      assign ch2_data_length_o[g*5 +: 5] = psr_len(f[4:0]);
    end
  endgenerate

endmodule

/* File: psr_host_model.sv */
`timescale 1ns/1ps
module psr_host_model (
  // clock and read data
  input wire ref_clk_i,
  input wire [15:0] rdata_i,
  // request lines
  output reg wr_en_o = 1'b0,
  output reg rd_en_o = 1'b0,
  output reg [5:0] addr_o = 6'h00,
  output reg [15:0] wdata_o = 16'h0000
);
  // ********
  // transfers
  // ********
  // released lines show the inverse, never a stale copy
  task wr(input [5:0] a, input [15:0] d);
  begin
    @(posedge ref_clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  end
  endtask
  // top bit picked so the word has odd parity
  task wp(input [5:0] a, input [15:0] d);
    wr(a, {~^d[14:0], d[14:0]});
  endtask
  task rd(input [5:0] a, output [15:0] d);
  begin
    @(posedge ref_clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    @(posedge ref_clk_i);
    #1;
    d = rdata_i;
  end
  endtask
endmodule

/* File: psr_config_regs_checker.sv */
`timescale 1ns/1ps
module psr_config_regs_checker (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // requests
  input wire ce_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [5:0] addr_i,
  input wire [15:0] wdata_i,
  // answers
  input wire parity_err_o,
  input wire lock_refused_o,
  input wire soft_reset_o,
  input wire ch1_upstream_clear_o,
  input wire ch2_upstream_clear_o,
  input wire prog_phase_o,
  input wire self_test_write_allowed_o,
  input wire self_test_setup_wr_en_o,
  input wire self_test_runtime_wr_en_o
);
  wire cmd_w = ce_i && wr_en_i && addr_i == 6'h1E;
  wire cfg_w = ce_i && wr_en_i && addr_i > 6'h16 && addr_i < 6'h22
    && addr_i != 6'h1E;
  reg unl_r;
  // unlock lives only until the next transfer of any kind
  always @(posedge ref_clk_i)
    if (rst_i)
      unl_r <= 1'b0;
    else if (ce_i && (wr_en_i || rd_en_i))
      unl_r <= cmd_w && wdata_i == 16'h5555;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  soft_rst_a: assert property (cmd_w && wdata_i == 16'hA5A5
    |=> soft_reset_o == $past(unl_r)) else $error("soft reset");
  clear_one_a: assert property (cmd_w && wdata_i == 16'h00FF
    |=> ch1_upstream_clear_o && !ch2_upstream_clear_o) else $error("clr1");
  clear_two_a: assert property (cmd_w && wdata_i == 16'hFF00
    |=> ch2_upstream_clear_o && !ch1_upstream_clear_o) else $error("clr2");
  lock_cmd_a: assert property (cmd_w && wdata_i == 16'h1111
    |=> !prog_phase_o && !self_test_setup_wr_en_o) else $error("lock");
  st_on_a: assert property (cmd_w && wdata_i == 16'h9999
    |=> self_test_write_allowed_o && self_test_runtime_wr_en_o
    && self_test_setup_wr_en_o == $past(prog_phase_o)) else $error("st on");
  st_off_a: assert property (cmd_w && wdata_i == 16'h9090
    |=> !self_test_write_allowed_o && !self_test_runtime_wr_en_o)
    else $error("st off");
  parity_chk_a: assert property (cfg_w && prog_phase_o && !(^wdata_i)
    |=> parity_err_o) else $error("parity");
  write_locked_a: assert property (cfg_w && !prog_phase_o && ^wdata_i
    |=> lock_refused_o) else $error("locked");
endmodule
bind psr_config_regs psr_config_regs_checker chk_u (.ref_clk_i, .rst_i,
  .ce_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .parity_err_o,
  .lock_refused_o, .soft_reset_o, .ch1_upstream_clear_o,
  .ch2_upstream_clear_o, .prog_phase_o, .self_test_write_allowed_o,
  .self_test_setup_wr_en_o, .self_test_runtime_wr_en_o);

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  // reset values 0x21 down to 0x16; the command register reads 0
  localparam [191:0] RV = {16'h0514, 16'h0514, 16'h0181, 16'h0000,
    16'h81EC, 16'h8000, 16'h8000, 16'h8000, 16'h8149, 16'h00B5,
    16'h002C, 16'h39AC};
  reg ref_clk_i, rst_i, clk_err_i, ce;
  reg [19:0] d = 20'h0;
  integer miscompares, comparisons, cyc, i;
  wire wr, rd, pe, lr, sr, c1, c2, pg, st, su, rt, ph, ro, ms, mp, ini;
  wire syn, bo;
  wire [5:0] ad;
  wire [15:0] wd, q;
  wire [4:0] i6, i5, i4;
  wire [71:0] es;
  wire [11:0] we;
  wire [1:0] il, br;
  wire [2:0] ns;
  wire [3:0] ct;
  wire [19:0] dl;
  psr_host_model host_u (.ref_clk_i(ref_clk_i), .rdata_i(q), .wr_en_o(wr),
    .rd_en_o(rd), .addr_o(ad), .wdata_o(wd));
  psr_config_regs dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .clk_err_i(clk_err_i), .wr_en_i(wr), .rd_en_i(rd), .addr_i(ad),
    .wdata_i(wd), .rdata_o(q), .parity_err_o(pe), .lock_refused_o(lr),
    .soft_reset_o(sr), .ch1_upstream_clear_o(c1),
    .ch2_upstream_clear_o(c2), .prog_phase_o(pg),
    .self_test_write_allowed_o(st), .self_test_setup_wr_en_o(su),
    .self_test_runtime_wr_en_o(rt), .ch1_slot6_sensor_id_o(i6),
    .ch1_slot5_sensor_id_o(i5), .ch1_slot4_sensor_id_o(i4),
    .ch1_slot_start_time_o(es), .ch1_window_end_time_o(we),
    .ch2_pulse_height_select_o(ph), .ch2_output_pin_role_o(ro),
    .ch2_monitor_standard_o(ms), .ch2_monitor_simple_o(mp),
    .ch2_current_limit_select_o(il), .ch2_store_init_data_o(ini),
    .ch2_slot_count_o(ns), .ch2_bit_rate_o(br),
    .ch2_synchronous_mode_o(syn), .ch2_bootstrap_off_o(bo),
    .ch2_check_type_o(ct), .ch2_data_length_o(dl));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // whole run needs about 120 cycles
  always @(posedge ref_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task chk(input [19:0] got, input [19:0] exp, input [47:0] msg);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: %0s %h", $time, msg, got);
    end
  end
  endtask
  task final_report;
  begin
    $display("compares %0d wrong %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task t_defaults;
  begin
    for (i = 0; i < 12; i = i + 1)
    begin
      host_u.rd(6'h16 + i[5:0], d[15:0]);
      chk(d, RV[i*16 +: 16], "reset");
    end
    host_u.rd(6'h3F, d[15:0]);
    chk(d, 20'h0, "unmap");
    chk({i6, i5, i4}, 20'h39AC, "ids");
    chk(we, 20'h1EC, "end");
    $display("defaults end");
  end
  endtask
  task t_windows;
  begin
    host_u.wr(6'h16, 16'hFFFF);
    chk({i6, i5, i4}, 20'h7FFF, "id");
    host_u.wp(6'h1C, 16'h0ABC);
    host_u.wp(6'h1D, 16'h0123);
    chk(es[71:60], 20'hABC, "start");
    chk(we, 20'h123, "end");
    host_u.wr(6'h1D, 16'h0457);
    chk(pe, 20'h1, "par");
    host_u.rd(6'h1D, d[15:0]);
    chk(d, 20'h8123, "kept");
    $display("windows end");
  end
  endtask
  task t_config;
  begin
    host_u.wp(6'h1F, 16'h3AE2);
    chk({ph, ro, ms, mp, ini, syn}, 20'h36, "flags");
    chk({il, ns, br}, 20'h59, "codes");
    host_u.wp(6'h20, 16'h17E8);
    chk({bo, ct}, 20'h1F, "fmt1");
    chk(dl, 20'h42108, "len1");
    host_u.wp(6'h1F, 16'h0577);
    chk({ms, mp, il, ns, br}, 20'h12C, "codes");
    chk(ct, 20'h1, "fmt2");
    chk(dl, 20'hA5288, "len2");
    $display("config end");
  end
  endtask
  task t_commands;
  begin
    // a command seen while the enable is low must leave no trace
    @(posedge ref_clk_i);
    ce <= 1'b0;
    host_u.wr(6'h1E, 16'h00FF);
    chk(c1, 20'h0, "frozen");
    @(posedge ref_clk_i);
    ce <= 1'b1;
    host_u.wr(6'h1E, 16'h00FF);
    chk({c1, c2}, 20'h2, "clr1");
    host_u.wr(6'h1E, 16'hFF00);
    chk({c1, c2}, 20'h1, "clr2");
    host_u.wr(6'h1E, 16'h9999);
    chk({st, su, rt}, 20'h7, "st on");
    host_u.wr(6'h1E, 16'h9090);
    chk({st, su, rt}, 20'h0, "st off");
    host_u.wr(6'h1E, 16'h5555);
    host_u.wr(6'h1E, 16'h1234);
    host_u.wr(6'h1E, 16'hA5A5);
    chk(sr, 20'h0, "norst");
    host_u.wr(6'h1E, 16'h5555);
    host_u.rd(6'h1F, d[15:0]);
    host_u.wr(6'h1E, 16'hA5A5);
    chk(sr, 20'h0, "norst");
    host_u.wr(6'h1E, 16'h5555);
    host_u.wr(6'h1E, 16'hA5A5);
    chk(sr, 20'h1, "rst");
    host_u.rd(6'h1F, d[15:0]);
    chk(d, 20'h0181, "rstval");
    $display("commands end");
  end
  endtask
  task t_lock;
  begin
    host_u.wr(6'h1E, 16'h9999);
    host_u.wr(6'h1E, 16'h1111);
    chk({pg, st, su, rt}, 20'h5, "lock");
    host_u.wp(6'h1F, 16'h0011);
    chk(lr, 20'h1, "refuse");
    host_u.rd(6'h1F, d[15:0]);
    chk(d, 20'h0181, "kept");
    @(posedge ref_clk_i);
    clk_err_i <= 1'b1;
    // two sync flops plus the state update
    repeat (4) @(posedge ref_clk_i);
    clk_err_i <= 1'b0;
    #1;
    chk({pg, st}, 20'h2, "clkerr");
    // let the synchronised error drain, else it overrides the lock
    repeat (3) @(posedge ref_clk_i);
    host_u.wr(6'h1E, 16'h1111);
    chk(pg, 20'h0, "relock");
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    chk(pg, 20'h1, "rstpin");
    $display("lock end");
  end
  endtask
  initial
  begin
    rst_i = 1'b1;
    ce = 1'b1;
    clk_err_i = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cyc = 0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_defaults;
    t_windows;
    t_config;
    t_commands;
    t_lock;
    final_report;
  end
endmodule
